// file: common/tt_irq_pkg.sv
/*
  Package for the time-triggered interrupt and application watchdog block:
  register offsets, flag positions, reset values and timing constants.
  Assumes a 16-bit register port addressed by byte offset.
*/
package tt_irq_pkg;
  localparam int          ADDR_W              = 8;
  localparam int          DATA_W              = 16;
  localparam int          FLAG_W              = 16;
  localparam logic [7:0]  OFS_MATRIX_LIMITS2  = 8'h2C;
  localparam logic [7:0]  OFS_WATCHDOG        = 8'h2E;
  localparam logic [7:0]  OFS_IRQ_ENABLE      = 8'h30;
  localparam logic [7:0]  OFS_IRQ_FLAGS       = 8'h32;
  localparam logic [7:0]  OFS_CONTROL         = 8'h40;
  // Flag positions in the enable and flag registers
  localparam int          BIT_CFG_ERR         = 15;
  localparam int          BIT_APP_WDG         = 14;
  localparam int          BIT_WATCH_TRIG      = 13;
  localparam int          BIT_INIT_WATCH      = 12;
  localparam int          BIT_TX_OVF          = 10;
  localparam int          BIT_TX_UNF          = 9;
  localparam int          BIT_GT_WRAP         = 6;
  localparam int          BIT_STOPWATCH       = 5;
  // Watchdog register fields
  localparam int          BIT_WDG_EXPIRED     = 15;
  localparam int          WDG_LIMIT_W         = 8;
  localparam logic [7:0]  WDG_LIMIT_RESET     = 8'h01;
  localparam logic [7:0]  WDG_LIMIT_OFF       = 8'h00;
  // Matrix limits 2 fields
  localparam int          CCM_LSB             = 0;
  localparam int          CCM_W               = 6;
  localparam int          TEW_LSB             = 8;
  localparam int          REF_MSG_LENGTH_CODE_LSB            = 12;
  localparam int          LEN_W               = 4;
  // Control register bits
  localparam int          BIT_CTL_IE          = 0;
  localparam int          BIT_CTL_CONFIG      = 1;
  localparam int          BIT_CTL_WATCHDOG_DISABLE_BIT       = 2;
  localparam int          BIT_ST_CCM_BAD      = 8;
  localparam int          BIT_ST_REF_MSG_LENGTH_CODE_BAD     = 9;
  localparam int          BIT_ST_SILENT       = 10;
  // Watchdog unit: 256 network time units
  localparam int          NTU_PER_WDG_UNIT    = 256;
  localparam int          WDG_PRESCALE_W      = 8;
  localparam logic [15:0] GT_MAX              = 16'hFFFF;
  localparam logic [15:0] GT_ZERO             = 16'h0000;
endpackage

// file: common/tt_event_if.sv
/*
  Interface carrying event pulses from the top into the flag register module.
  Assumes one shared clock.
*/
`timescale 1ns/1ps
interface tt_event_if;
  logic [tt_irq_pkg::FLAG_W-1:0] set_pulse;
  logic [tt_irq_pkg::FLAG_W-1:0] clear_mask;
  logic                          clear_write;
  logic [tt_irq_pkg::FLAG_W-1:0] flags;
  modport source (output set_pulse, output clear_mask, output clear_write, input flags);
  modport sink   (input set_pulse, input clear_mask, input clear_write, output flags);
endinterface

// file: design/tt_flag_reg.sv
/*
  Sticky event flag register: hardware sets, software clears by writing zero.
  Assumes set pulses and the clear write share clock_i.
*/
`timescale 1ns/1ps
module tt_flag_reg (
  input  wire logic   clock_i,
  input  wire logic   resetn_i,
  tt_event_if.sink    ev
);
  logic [tt_irq_pkg::FLAG_W-1:0] flags;
  logic [tt_irq_pkg::FLAG_W-1:0] next_flags;
  logic [tt_irq_pkg::FLAG_W-1:0] kept;

  assign kept = ev.clear_write ? (flags & ev.clear_mask) : flags;
  // set regardless of enables; set wins over clear
  assign next_flags = kept | ev.set_pulse;
  assign ev.flags = flags;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule // tt_flag_reg

// file: design/tt_interrupt_and_app_watchdog.sv
/*
  Time-triggered interrupt enables, event flags and application watchdog.
  Assumes event inputs are one-cycle pulses and ntu_tick_i pulses once per
  network time unit, all synchronous to clock_i.
*/
// Chosen here: the strobed register port.
//
// Contract
// - last_cycle_index gives matrix cycles minus one; only all-ones patterns legal.
// - Watchdog limit is longest service interval in units of 256 NETWORK_TIME_UNIT.
// - Reading watchdog upper byte services and restarts the interval.
// - Expiry sets expired flag, halts communication, forces silent mode.
// - Watchdog off when disable bit set and limit is zero.
// - One enable bit per flag at the same position.
// - Flags set on their conditions regardless of enables.
// - Interrupt asserted while any flag and its enable are both one.
// - Interrupt also gated by module interrupt enable.
// - Flags stay set until software clear or hardware reset.
// - Writing zero clears a flag, writing one keeps it.
// - Trigger list error sets configuration error flag.
// - Watchdog expiry sets application watchdog flag.
// - Active watch trigger sets watch trigger flag.
// - Clearing init watch trigger flag restarts start-up initialisation.
// - Too many transmit triggers sets overflow, too few sets underflow.
// - Global time roll-over from FFFF to 0000 sets wrap flag.
// - Stopwatch input rising edge sets stopwatch flag.
`timescale 1ns/1ps
module tt_interrupt_and_app_watchdog (
  input  wire logic                             clock_i,
  input  wire logic                             resetn_i,
  input  wire logic [tt_irq_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [tt_irq_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                             write_i,
  input  wire logic                             read_i,
  output logic      [tt_irq_pkg::DATA_W-1:0]    rdata_o,
  input  wire logic                             ntu_tick_i,
  input  wire logic                             trigger_list_error_i,
  input  wire logic                             watch_trigger_i,
  input  wire logic                             init_watch_trigger_i,
  input  wire logic                             tx_matrix_end_i,
  input  wire logic [11:0]                      tx_trigger_count_i,
  input  wire logic [11:0]                      expected_tx_count_i,
  input  wire logic [15:0]                      global_time_i,
  input  wire logic                             stopwatch_i,
  input  wire logic [tt_irq_pkg::FLAG_W-3:0]    other_events_i,
  output logic                                  tt_irq_o,
  output logic                                  comm_halt_o,
  output logic                                  silent_mode_o,
  output logic                                  init_restart_o,
  output logic [tt_irq_pkg::CCM_W-1:0]          last_cycle_index_o,
  output logic [tt_irq_pkg::LEN_W-1:0]          tx_enable_window_len_o,
  output logic [tt_irq_pkg::LEN_W-1:0]          ref_msg_length_code_o
);
  localparam int FW = tt_irq_pkg::FLAG_W;

  tt_event_if ev ();

  logic [FW-1:0]                          irq_enable;
  logic                                   module_interrupt_enable;
  logic                                   config_mode;
  logic                                   watchdog_disable_bit;
  logic                                   wdg_expired;
  logic [tt_irq_pkg::WDG_LIMIT_W-1:0]     app_watchdog_limit;
  logic [tt_irq_pkg::CCM_W-1:0]           last_cycle_index;
  logic [tt_irq_pkg::LEN_W-1:0]           tx_enable_window_len;
  logic [tt_irq_pkg::LEN_W-1:0]           ref_msg_length_code;
  logic [tt_irq_pkg::WDG_PRESCALE_W-1:0]  ntu_prescale;
  logic [tt_irq_pkg::WDG_LIMIT_W-1:0]     wdg_units;
  logic [15:0]                            gt_prev;
  logic                                   stopwatch_prev;
  logic                                   init_restart;
  logic [tt_irq_pkg::DATA_W-1:0]          rdata;

  function automatic logic hit(input logic [tt_irq_pkg::ADDR_W-1:0] ofs);
    return addr_i == ofs;
  endfunction

  // Register decode
  wire wr_ml2   = write_i & hit(tt_irq_pkg::OFS_MATRIX_LIMITS2);
  wire wr_wdg   = write_i & hit(tt_irq_pkg::OFS_WATCHDOG);
  wire wr_en    = write_i & hit(tt_irq_pkg::OFS_IRQ_ENABLE);
  wire wr_flags = write_i & hit(tt_irq_pkg::OFS_IRQ_FLAGS);
  wire wr_ctl   = write_i & hit(tt_irq_pkg::OFS_CONTROL);
  wire cfg_wr   = config_mode;

  // read of upper byte services watchdog
  wire wdg_service = read_i & hit(tt_irq_pkg::OFS_WATCHDOG);
  wire wdg_off = watchdog_disable_bit & (app_watchdog_limit == tt_irq_pkg::WDG_LIMIT_OFF);
  wire unit_tick = ntu_tick_i &
    (ntu_prescale == tt_irq_pkg::WDG_PRESCALE_W'(tt_irq_pkg::NTU_PER_WDG_UNIT - 1));
  // the unit ending now completes the allowed interval
  wire [tt_irq_pkg::WDG_LIMIT_W:0] units_done = {1'b0, wdg_units} + 1'b1;
  // A service in the cycle of the last tick still counts as on time
  wire wdg_fire = ~wdg_off & ~wdg_expired & unit_tick &
    (units_done >= {1'b0, app_watchdog_limit}) & ~wdg_service;
  // clear expired only in configuration mode
  wire wdg_clear = wr_wdg & config_mode & ~wdata_i[tt_irq_pkg::BIT_WDG_EXPIRED];

  // An all-ones pattern plus one shares no set bit with itself
  // legal cycle count patterns are all-ones
  wire ccm_bad = |((last_cycle_index + tt_irq_pkg::CCM_W'(1)) & last_cycle_index);
  wire ref_msg_length_code_bad = (ref_msg_length_code == '0);

  // compare transmit count at matrix end
  wire tx_ovf = tx_matrix_end_i & (tx_trigger_count_i > expected_tx_count_i);
  wire tx_unf = tx_matrix_end_i & (tx_trigger_count_i < expected_tx_count_i);
  wire gt_wrap = (gt_prev == tt_irq_pkg::GT_MAX) & (global_time_i == tt_irq_pkg::GT_ZERO);
  wire sw_rise = stopwatch_i & ~stopwatch_prev;

  // Map the event sources onto their flag positions
  logic [FW-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[tt_irq_pkg::BIT_TX_UNF - 1:0] = other_events_i[tt_irq_pkg::BIT_TX_UNF - 1:0];
    set_vec[tt_irq_pkg::BIT_TX_OVF + 1]   = other_events_i[tt_irq_pkg::BIT_TX_UNF];
    set_vec[tt_irq_pkg::BIT_TX_UNF]     |= tx_unf;
    set_vec[tt_irq_pkg::BIT_TX_OVF]     |= tx_ovf;
    set_vec[tt_irq_pkg::BIT_GT_WRAP]    |= gt_wrap;
    set_vec[tt_irq_pkg::BIT_STOPWATCH]  |= sw_rise;
    set_vec[tt_irq_pkg::BIT_CFG_ERR]     = trigger_list_error_i;
    set_vec[tt_irq_pkg::BIT_APP_WDG]     = wdg_fire;
    set_vec[tt_irq_pkg::BIT_WATCH_TRIG]  = watch_trigger_i;
    set_vec[tt_irq_pkg::BIT_INIT_WATCH]  = init_watch_trigger_i;
  end

  // Software reaches the flags only through a write to the flag register
  assign ev.set_pulse   = set_vec;
  assign ev.clear_mask  = wdata_i;
  assign ev.clear_write = wr_flags;

  tt_flag_reg u_flags (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .ev       (ev.sink)
  );

  // No restart when a new trigger lands beside the clear, as the flag stays set
  // clearing the init watch flag restarts initialisation
  wire next_init_restart = wr_flags & ev.flags[tt_irq_pkg::BIT_INIT_WATCH] &
    ~wdata_i[tt_irq_pkg::BIT_INIT_WATCH] & ~init_watch_trigger_i;

  // enables and control bits cleared by reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_enable              <= '0;
      module_interrupt_enable <= 1'b0;
      config_mode             <= 1'b0;
      watchdog_disable_bit    <= 1'b0;
    end else begin
      if (wr_en) begin
        irq_enable <= wdata_i;
      end
      if (wr_ctl) begin
        module_interrupt_enable <= wdata_i[tt_irq_pkg::BIT_CTL_IE];
        config_mode             <= wdata_i[tt_irq_pkg::BIT_CTL_CONFIG];
        watchdog_disable_bit    <= wdata_i[tt_irq_pkg::BIT_CTL_WATCHDOG_DISABLE_BIT];
      end
    end
  end

  // Configuration fields change only in configuration mode
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      app_watchdog_limit   <= tt_irq_pkg::WDG_LIMIT_RESET;
      last_cycle_index     <= '0;
      tx_enable_window_len <= '0;
      ref_msg_length_code  <= '0;
    end else begin
      if (wr_wdg & cfg_wr) begin
        app_watchdog_limit <= wdata_i[tt_irq_pkg::WDG_LIMIT_W-1:0];
      end
      if (wr_ml2 & cfg_wr) begin
        last_cycle_index     <= wdata_i[tt_irq_pkg::CCM_LSB +: tt_irq_pkg::CCM_W];
        tx_enable_window_len <= wdata_i[tt_irq_pkg::TEW_LSB +: tt_irq_pkg::LEN_W];
        ref_msg_length_code  <= wdata_i[tt_irq_pkg::REF_MSG_LENGTH_CODE_LSB +: tt_irq_pkg::LEN_W];
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ntu_prescale <= '0;
      wdg_units    <= '0;
    end else if (wdg_service | wdg_off | wdg_expired) begin
      ntu_prescale <= '0;
      wdg_units    <= '0;
    end else if (ntu_tick_i) begin
      ntu_prescale <= ntu_prescale + 1'b1;
      if (unit_tick) begin
        wdg_units <= wdg_units + 1'b1;
      end
    end
  end

  // expiry latches halt and silent mode
  // cleared only by reset or a config-mode write of zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdg_expired <= 1'b0;
    end else if (wdg_fire) begin
      wdg_expired <= 1'b1;
    end else if (wdg_clear) begin
      wdg_expired <= 1'b0;
    end
  end

  // Previous samples for the wrap and rising-edge detectors, and the registered init restart pulse
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gt_prev        <= '0;
      stopwatch_prev <= 1'b0;
      init_restart   <= 1'b0;
    end else begin
      gt_prev        <= global_time_i;
      stopwatch_prev <= stopwatch_i;
      init_restart   <= next_init_restart;
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    unique case (addr_i)
      tt_irq_pkg::OFS_MATRIX_LIMITS2: begin
        rdata = '0;
        rdata[tt_irq_pkg::CCM_LSB +: tt_irq_pkg::CCM_W]  = last_cycle_index;
        rdata[tt_irq_pkg::TEW_LSB +: tt_irq_pkg::LEN_W]  = tx_enable_window_len;
        rdata[tt_irq_pkg::REF_MSG_LENGTH_CODE_LSB +: tt_irq_pkg::LEN_W] = ref_msg_length_code;
      end
      tt_irq_pkg::OFS_WATCHDOG: begin
        rdata = '0;
        rdata[tt_irq_pkg::WDG_LIMIT_W-1:0]        = app_watchdog_limit;
        rdata[tt_irq_pkg::BIT_WDG_EXPIRED]        = wdg_expired;
      end
      tt_irq_pkg::OFS_IRQ_ENABLE: rdata = irq_enable;
      tt_irq_pkg::OFS_IRQ_FLAGS:  rdata = ev.flags;
      tt_irq_pkg::OFS_CONTROL: begin
        rdata = '0;
        rdata[tt_irq_pkg::BIT_CTL_IE]      = module_interrupt_enable;
        rdata[tt_irq_pkg::BIT_CTL_CONFIG]  = config_mode;
        rdata[tt_irq_pkg::BIT_CTL_WATCHDOG_DISABLE_BIT]   = watchdog_disable_bit;
        rdata[tt_irq_pkg::BIT_ST_CCM_BAD]  = ccm_bad;
        rdata[tt_irq_pkg::BIT_ST_REF_MSG_LENGTH_CODE_BAD] = ref_msg_length_code_bad;
        rdata[tt_irq_pkg::BIT_ST_SILENT]   = wdg_expired;
      end
      default: rdata = '0;
    endcase
  end

  // Read data stand for one cycle only, then return to zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (read_i) begin
      rdata_o <= rdata;
    end else begin
      rdata_o <= '0;
    end
  end

  // any enabled flag raises the request while the module interrupt enable is set
  assign tt_irq_o = module_interrupt_enable & (|(ev.flags & irq_enable));
  // halt and silent mode follow the expired flag
  assign comm_halt_o            = wdg_expired;
  assign silent_mode_o          = wdg_expired;
  assign init_restart_o         = init_restart;
  assign last_cycle_index_o     = last_cycle_index;
  assign tx_enable_window_len_o = tx_enable_window_len;
  assign ref_msg_length_code_o  = ref_msg_length_code;
endmodule // tt_interrupt_and_app_watchdog

// file: testbench/tt_irq_monitor.sv
/* Port checker for the time-triggered interrupt and watchdog block.
   Assumes it is bound into the top module on one clock. */
`timescale 1ns/1ps
module tt_irq_monitor (
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [15:0] rdata_o,
  input wire logic        ntu_tick_i,
  input wire logic        tt_irq_o,
  input wire logic        comm_halt_o,
  input wire logic        silent_mode_o,
  input wire logic        init_restart_o,
  input wire logic [5:0]  last_cycle_index_o,
  input wire logic [3:0]  ref_msg_length_code_o
);
  wire logic wr_flags = write_i && addr_i == 8'h32;
  wire logic wr_wdg   = write_i && addr_i == 8'h2E;
  wire logic wr_lim   = write_i && addr_i == 8'h2C;
  wire logic wr_irq   = write_i && (addr_i == 8'h30 || addr_i == 8'h32 || addr_i == 8'h40);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_idle_bus; !read_i; endsequence
  sequence s_expiry; $rose(comm_halt_o); endsequence
  a_rdata_idle: assert property (s_idle_bus |=> rdata_o == 16'h0000)
    else $error("read data not zero without a read");
  a_halt_silent: assert property (comm_halt_o == silent_mode_o)
    else $error("halt and silent outputs differ");
  a_expire_tick: assert property (s_expiry |-> $past(ntu_tick_i))
    else $error("watchdog expired without a unit tick");
  a_resume_write: assert property ($fell(comm_halt_o) |-> $past(wr_wdg) && !$past(wdata_i[15]))
    else $error("halt released without expired bit write");
  a_init_restart: assert property (init_restart_o |-> ($past(wr_flags) && !$past(wdata_i[12]))
    || ($past(wr_flags, 2) && !$past(wdata_i[12], 2)))
    else $error("restart pulse without init flag clear");
  a_irq_sticky: assert property ($fell(tt_irq_o) |-> $past(wr_irq))
    else $error("interrupt dropped without software write");
  a_reset_clear: assert property ($rose(resetn_i) |-> !tt_irq_o && !comm_halt_o
    && last_cycle_index_o == 6'h00)
    else $error("outputs not cleared by reset");
  a_index_load: assert property ($changed(last_cycle_index_o) |-> $past(wr_lim)
    && last_cycle_index_o == $past(wdata_i[5:0]))
    else $error("cycle index changed without write");
  a_code_load: assert property ($changed(ref_msg_length_code_o) |-> $past(wr_lim)
    && ref_msg_length_code_o == $past(wdata_i[15:12]))
    else $error("length code changed without write");
endmodule // tt_irq_monitor
bind tt_interrupt_and_app_watchdog tt_irq_monitor u_monitor (.clock_i(clock_i),
  .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
  .read_i(read_i), .rdata_o(rdata_o), .ntu_tick_i(ntu_tick_i), .tt_irq_o(tt_irq_o),
  .comm_halt_o(comm_halt_o), .silent_mode_o(silent_mode_o), .init_restart_o(init_restart_o),
  .last_cycle_index_o(last_cycle_index_o), .ref_msg_length_code_o(ref_msg_length_code_o));

// file: testbench/tt_interrupt_and_app_watchdog_bench.sv
/* Self-checking bench for the interrupt and watchdog block.
   Assumes the checker is bound in and ticks come from the bench. */
`timescale 1ns/1ps
module tt_interrupt_and_app_watchdog_bench;
  logic        clock_i = 1'b0, resetn_i = 1'b0, write_i = 1'b0, read_i = 1'b0;
  logic        ntu_tick_i = 1'b0, trigger_list_error_i = 1'b0, watch_trigger_i = 1'b0;
  logic        init_watch_trigger_i = 1'b0, tx_matrix_end_i = 1'b0, stopwatch_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, global_time_i = 16'h0000, rdata_o, v, d;
  logic [11:0] tx_trigger_count_i = 12'h004, expected_tx_count_i = 12'h004;
  logic [13:0] other_events_i = 14'h0000;
  logic        tt_irq_o, comm_halt_o, silent_mode_o, init_restart_o;
  logic [5:0]  last_cycle_index_o;
  logic [3:0]  tx_enable_window_len_o, ref_msg_length_code_o;
  integer      seed = 32'h973256c8;
  int          num_errors = 0, compares = 0, n;
  logic [15:0] flags = 16'h0000, en = 16'h0000, ctl = 16'h0000;
  always #5 clock_i = ~clock_i;
  tt_interrupt_and_app_watchdog DUT (.clock_i, .resetn_i, .addr_i, .wdata_i, .write_i,
    .read_i, .rdata_o, .ntu_tick_i, .trigger_list_error_i, .watch_trigger_i,
    .init_watch_trigger_i, .tx_matrix_end_i, .tx_trigger_count_i, .expected_tx_count_i,
    .global_time_i, .stopwatch_i, .other_events_i, .tt_irq_o, .comm_halt_o, .silent_mode_o,
    .init_restart_o, .last_cycle_index_o, .tx_enable_window_len_o, .ref_msg_length_code_o);
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    compares++;
    if (seen !== expd) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bus write; the model tracks flag, enable and control register writes
  task automatic wr(input logic [7:0] a, input logic [15:0] x);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= x;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
    if (a == 8'h32) flags &= x;
    if (a == 8'h30) en = x;
    if (a == 8'h40) ctl = x;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic ev(input logic [15:0] m);
    @(posedge clock_i);
    trigger_list_error_i <= m[15];
    watch_trigger_i <= m[13];
    init_watch_trigger_i <= m[12];
    other_events_i <= {4'h0, m[11], m[8:0]};
    @(posedge clock_i);
    {trigger_list_error_i, watch_trigger_i, init_watch_trigger_i} <= 3'b000;
    other_events_i <= 14'h0000;
    flags |= m;
    #1;
  endtask
  task automatic src(input logic [11:0] c, input logic [15:0] g, input logic s,
                     input logic [15:0] m);
    @(posedge clock_i);
    tx_trigger_count_i <= c;
    global_time_i <= g;
    stopwatch_i <= s;
    tx_matrix_end_i <= 1'b1;
    @(posedge clock_i);
    tx_matrix_end_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    flags |= m;
    rd(8'h32);
  endtask
  task automatic chk_irq;
    check({15'h0, tt_irq_o}, {15'h0, ctl[0] && ((flags & en) != 16'h0000)});
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(8'h32); check(v, 16'h0000);
    rd(8'h30); check(v, 16'h0000);
    rd(8'h2E); check(v, {8'h00, tt_irq_pkg::WDG_LIMIT_RESET});
    rd(8'h50); check(v, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 24; i++) begin
      wr(8'h30, 16'($random(seed)));
      wr(8'h40, 16'($random(seed)) & 16'h0001);
      ev(16'($random(seed)) & 16'hB9FF);
      chk_irq();
      wr(8'h32, 16'($random(seed)) | 16'($random(seed)));
      rd(8'h32); check(v, flags);
      chk_irq();
    end
    $display("flags and enables done");
    wr(8'h32, 16'h0000);
    src(12'h004, 16'hFFFE, 1'b0, 16'h0000); check(v, flags);
    src(12'h005, 16'hFFFF, 1'b0, 16'h0400); check(v, flags);
    src(12'h003, 16'h0000, 1'b1, 16'h0260); check(v, flags);
    src(12'h004, 16'h0001, 1'b1, 16'h0000); check(v, flags);
    ev(16'h1000);
    wr(8'h32, 16'hEFFF);
    v[0] = init_restart_o;
    @(posedge clock_i);
    #1 v[1] = init_restart_o;
    check({14'h0, v[1:0]}, 16'h0001);
    $display("event sources done");
    wr(8'h40, 16'h0002);
    wr(8'h2E, 16'h0002);
    wr(8'h32, 16'h0000);
    ntu_tick_i <= 1'b1;
    repeat (4) begin
      repeat (200) @(posedge clock_i);
      rd(8'h2E);
    end
    check({15'h0, comm_halt_o}, 16'h0000);
    n = 0;
    while (comm_halt_o !== 1'b1 && n < 1000) begin
      @(posedge clock_i);
      #1 n++;
    end
    ntu_tick_i <= 1'b0;
    if (n == 1000) begin
      num_errors++;
      finish_test();
    end
    check(16'(n > 250 && n <= 520), 16'h0001);
    flags |= 16'h4000;
    rd(8'h2E); check(v, 16'h8002);
    rd(8'h32); check(v, flags);
    wr(8'h40, 16'h0000);
    wr(8'h2E, 16'h0002); check({14'h0, comm_halt_o, silent_mode_o}, 16'h0003);
    wr(8'h40, 16'h0002);
    wr(8'h2E, 16'h0002); check({14'h0, comm_halt_o, silent_mode_o}, 16'h0000);
    wr(8'h40, 16'h0006);
    wr(8'h2E, 16'h0000);
    ntu_tick_i <= 1'b1;
    repeat (600) @(posedge clock_i);
    ntu_tick_i <= 1'b0;
    #1 check({15'h0, comm_halt_o}, 16'h0000);
    $display("watchdog done");
    wr(8'h40, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      d = (16'($random(seed)) & 16'hFF00) | ((i < 7) ? 16'((1 << i) - 1) : 16'h0005);
      if (i == 0) d[15:12] = 4'h0;
      wr(8'h2C, d);
      check({ref_msg_length_code_o, tx_enable_window_len_o, 2'b00, last_cycle_index_o}, d);
      rd(8'h40); check(v & 16'h0300, {6'h00, d[15:12] == 4'h0, i == 7, 8'h00});
    end
    wr(8'h40, 16'h0000);
    wr(8'h2C, 16'h1111);
    check({ref_msg_length_code_o, tx_enable_window_len_o, 2'b00, last_cycle_index_o}, d);
    $display("matrix limits done");
    finish_test();
  end
endmodule // tt_interrupt_and_app_watchdog_bench
